// *** rtl/ddsl_defs.svh ***
// Register offsets, field positions, reset values and word layout of the serial loader
`ifndef DDSL_DEFS_SVH
`define DDSL_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DDSL_OFF_CTRL      8'h00
`define DDSL_OFF_DAC_A     8'h04
`define DDSL_OFF_DAC_B     8'h08
`define DDSL_OFF_STAGE     8'h0c
`define DDSL_OFF_CONFIG    8'h10
`define DDSL_OFF_LAST      8'h14
`define DDSL_OFF_COUNT     8'h18

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define DDSL_CTRL_ACCEPT   0
`define DDSL_CTRL_CLEAR    1
`define DDSL_CTRL_RESET    2'h1

// ****************************************************************
// Config and last-word register read layouts
// ****************************************************************
`define DDSL_CFG_REF_LO    0
`define DDSL_CFG_REF_HI    1
`define DDSL_CFG_SPEED     4
`define DDSL_CFG_PWRDN     5
`define DDSL_LAST_PARTIAL  16

// ****************************************************************
// Serial word layout
// ****************************************************************
`define DDSL_WORD_BITS     16
`define DDSL_CODE_BITS     12
`define DDSL_BIT_TGT_HI    15
`define DDSL_BIT_SPEED     14
`define DDSL_BIT_PWRDN     13
`define DDSL_BIT_TGT_LO    12
`define DDSL_BIT_REF_HI    1
`define DDSL_BIT_REF_LO    0
`define DDSL_FULL_COUNT    5'h10

`endif

// *** rtl/ddsl_pkg.sv ***
// Types shared by the dual DAC serial loader
`default_nettype none

package ddsl_pkg;
  typedef enum logic [1:0]
  {
    DDSL_TGT_B_AND_STAGE,
    DDSL_TGT_STAGE,
    DDSL_TGT_A_AND_COPY,
    DDSL_TGT_CONFIG
  } ddsl_target_t;

  typedef logic [11:0] ddsl_code_t;
  typedef logic [15:0] ddsl_word_t;
endpackage

`default_nettype wire

// *** rtl/ddsl_top.sv ***
// Serial write port, target latches and APB register file of the dual DAC loader
//
// Functional notes
// - Select falling edge starts a word; one bit shifts per serial clock fall.
// - Word arrives most significant bit first, sampled on falling serial clock edges.
// - After sixteen bits the word moves to its target latch unprompted.
// - Select rising edge also moves a partial word (1 to 15 bits) from the shift register into the target latch.
// - Control bits of the received word choose the destination latch.
// - Last bit sampled on sixteenth fall; host keeps select low past it.
// - Addressed latches update automatically once the sixteenth bit completes.
// - All internal latches clear to zero at power-up.
// - Channel codes are unsigned straight binary 0x000 to 0xfff.
// - Top and fourth bits pick B+stage, stage, A+copy, or configuration.
// - Second-highest bit set selects fast settling, clear selects slow.
// - Third-highest bit set powers down, clear is normal operation.
// - Configuration writes take reference from two lowest bits; speed and power-down bits still apply, rest ignored.
`timescale 1ns/1ps
`include "ddsl_defs.svh"
`default_nettype none

module ddsl_top
(
  input  wire logic                mclk,              // System clock, 25 MHz
  input  wire logic                arst_n,            // Asynchronous reset, active low
  input  wire logic                psel,              // APB select
  input  wire logic                penable,           // APB access phase
  input  wire logic                pwrite,            // APB write
  input  wire logic [7:0]          paddr,             // APB byte address
  input  wire logic [31:0]         pwdata,            // APB write data
  output logic      [31:0]         prdata,            // APB read data
  output logic                     pready,            // APB ready
  output logic                     pslverr,           // APB error on unmapped address
  input  wire logic                sclk,              // Serial clock from host
  input  wire logic                sel_n,             // Serial select, active low
  input  wire logic                sdin,              // Serial data in
  output ddsl_pkg::ddsl_code_t     dac_a_code,        // Channel A code latch
  output ddsl_pkg::ddsl_code_t     dac_b_code,        // Channel B code latch
  output logic                     speed_select,      // Fast settling when high
  output logic                     powerdown_select,  // Power-down when high
  output logic [1:0]               reference_select   // Reference selection bits
);
  import ddsl_pkg::*;

  // ****************************************************************
  // Link domain: shifting on the serial clock
  // ****************************************************************
  logic        armed_q;
  logic [4:0]  cnt_q;
  ddsl_word_t  shift_q;
  ddsl_word_t  word_q;
  logic        word_tog_q;
  logic        start_bit;
  logic [4:0]  cnt_base;
  ddsl_word_t  shift_base;

  // Armed is preset while deselected so that the next fall starts fresh
  always_ff @(negedge sclk or posedge sel_n)
  begin
    if (sel_n)
      armed_q <= 1'b1;
    else
      armed_q <= 1'b0;
  end

  // A new word starts on the first fall of a frame or after a full word
  assign start_bit  = armed_q || (cnt_q == `DDSL_FULL_COUNT);
  assign cnt_base   = start_bit ? 5'h00 : cnt_q;
  assign shift_base = start_bit ? 16'h0000 : shift_q;

  // Edges while deselected are ignored; count and shift hold for the fabric side
  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q   <= 5'h00;
      shift_q <= 16'h0000;
    end
    else if (!sel_n)
    begin
      cnt_q   <= cnt_base + 5'h01;
      shift_q <= {shift_base[14:0], sdin};
    end
  end

  // Full word captured and announced by a toggle
  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      word_q     <= 16'h0000;
      word_tog_q <= 1'b0;
    end
    else if (!sel_n && cnt_base == (`DDSL_FULL_COUNT - 5'h01))
    begin
      word_q     <= {shift_base[14:0], sdin};
      word_tog_q <= ~word_tog_q;
    end
  end

  // ****************************************************************
  // Crossing into the system clock domain
  // ****************************************************************
  logic [2:0] tog_sync_q;
  logic [2:0] sel_sync_q;
  logic       full_evt;
  logic       rise_evt;
  logic       partial_evt;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tog_sync_q <= 3'h0;
      sel_sync_q <= 3'h7;
    end
    else
    begin
      tog_sync_q <= {tog_sync_q[1:0], word_tog_q};
      sel_sync_q <= {sel_sync_q[1:0], sel_n};
    end
  end

  assign full_evt = tog_sync_q[2] ^ tog_sync_q[1];
  assign rise_evt = sel_sync_q[1] & ~sel_sync_q[2];
  // Count and shift are static while deselected, so they are safe to read here.
  // A full word already went over the toggle path and is not sent twice.
  // Limitation: a frame raised with no clock falls may re-send a stale partial word.
  assign partial_evt = rise_evt && (cnt_q != 5'h00) && (cnt_q != `DDSL_FULL_COUNT);

  // ****************************************************************
  // Word decode
  // ****************************************************************
  logic         apply;
  ddsl_word_t   rx_word;
  ddsl_target_t tgt;
  ddsl_code_t   rx_code;
  logic         accept_q;

  assign rx_word = full_evt ? word_q : shift_q;
  assign apply   = (full_evt || partial_evt) && accept_q;
  assign tgt     = ddsl_target_t'({rx_word[`DDSL_BIT_TGT_HI], rx_word[`DDSL_BIT_TGT_LO]});
  assign rx_code = rx_word[`DDSL_CODE_BITS-1:0];

  // ****************************************************************
  // Target latches
  // ****************************************************************
  ddsl_code_t dac_a_q;
  ddsl_code_t dac_b_q;
  ddsl_code_t stage_q;
  logic [1:0] ref_q;
  logic       speed_q;
  logic       pwrdn_q;
  logic       clear_cmd;

  // A word arriving with a software clear still lands: the clear runs first
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_a_q <= 12'h000;
      dac_b_q <= 12'h000;
      stage_q <= 12'h000;
      ref_q   <= 2'h0;
      speed_q <= 1'b0;
      pwrdn_q <= 1'b0;
    end
    else if (apply)
    begin
      speed_q <= rx_word[`DDSL_BIT_SPEED];
      pwrdn_q <= rx_word[`DDSL_BIT_PWRDN];
      case (tgt)
        DDSL_TGT_B_AND_STAGE:
        begin
          dac_b_q <= rx_code;
          stage_q <= rx_code;
          if (clear_cmd)
          begin
            dac_a_q <= 12'h000;
            ref_q   <= 2'h0;
          end
        end
        DDSL_TGT_STAGE:
        begin
          stage_q <= rx_code;
          if (clear_cmd)
          begin
            dac_a_q <= 12'h000;
            dac_b_q <= 12'h000;
            ref_q   <= 2'h0;
          end
        end
        DDSL_TGT_A_AND_COPY:
        begin
          dac_a_q <= rx_code;
          // The copy sees the stage value as already cleared
          dac_b_q <= clear_cmd ? 12'h000 : stage_q;
          if (clear_cmd)
          begin
            stage_q <= 12'h000;
            ref_q   <= 2'h0;
          end
        end
        default:
        begin
          ref_q <= {rx_word[`DDSL_BIT_REF_HI], rx_word[`DDSL_BIT_REF_LO]};
          if (clear_cmd)
          begin
            dac_a_q <= 12'h000;
            dac_b_q <= 12'h000;
            stage_q <= 12'h000;
          end
        end
      endcase
    end
    else if (clear_cmd)
    begin
      dac_a_q <= 12'h000;
      dac_b_q <= 12'h000;
      stage_q <= 12'h000;
      ref_q   <= 2'h0;
      speed_q <= 1'b0;
      pwrdn_q <= 1'b0;
    end
  end

  assign dac_a_code       = dac_a_q;
  assign dac_b_code       = dac_b_q;
  assign speed_select     = speed_q;
  assign powerdown_select = pwrdn_q;
  assign reference_select = ref_q;

  // ****************************************************************
  // Receive status
  // ****************************************************************
  ddsl_word_t  last_q;
  logic        last_partial_q;
  logic [31:0] count_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_q         <= 16'h0000;
      last_partial_q <= 1'b0;
      count_q        <= 32'h0000_0000;
    end
    else if (full_evt || partial_evt)
    begin
      last_q         <= rx_word;
      last_partial_q <= ~full_evt;
      count_q        <= count_q + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // APB slave: zero wait states
  // ****************************************************************
  logic hit_ctrl;
  logic hit_a;
  logic hit_b;
  logic hit_stage;
  logic hit_cfg;
  logic hit_last;
  logic hit_count;
  logic mapped;
  logic wr_ctrl;
  logic acc_phase;
  logic rd_setup;

  assign hit_ctrl  = (paddr == `DDSL_OFF_CTRL);
  assign hit_a     = (paddr == `DDSL_OFF_DAC_A);
  assign hit_b     = (paddr == `DDSL_OFF_DAC_B);
  assign hit_stage = (paddr == `DDSL_OFF_STAGE);
  assign hit_cfg   = (paddr == `DDSL_OFF_CONFIG);
  assign hit_last  = (paddr == `DDSL_OFF_LAST);
  assign hit_count = (paddr == `DDSL_OFF_COUNT);
  assign mapped    = hit_ctrl | hit_a | hit_b | hit_stage | hit_cfg | hit_last | hit_count;
  assign acc_phase = psel && penable;
  assign rd_setup  = psel && !penable && !pwrite;
  assign wr_ctrl   = acc_phase && pwrite && hit_ctrl;
  assign clear_cmd = wr_ctrl && pwdata[`DDSL_CTRL_CLEAR];
  assign pready    = 1'b1;
  assign pslverr   = acc_phase && !mapped;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      accept_q <= 1'b1;
    else if (wr_ctrl)
      accept_q <= pwdata[`DDSL_CTRL_ACCEPT];
  end

  logic [31:0] rd_mux;
  logic [31:0] cfg_word;
  logic [31:0] last_word;

  // Read layouts follow the field positions so they track the header
  always_comb
  begin
    cfg_word                                    = 32'h0000_0000;
    cfg_word[`DDSL_CFG_REF_HI:`DDSL_CFG_REF_LO] = ref_q;
    cfg_word[`DDSL_CFG_SPEED]                   = speed_q;
    cfg_word[`DDSL_CFG_PWRDN]                   = pwrdn_q;
    last_word                                   = 32'h0000_0000;
    last_word[`DDSL_WORD_BITS-1:0]              = last_q;
    last_word[`DDSL_LAST_PARTIAL]               = last_partial_q;
  end

  always_comb
  begin
    if (hit_ctrl)
      rd_mux = {31'h0, accept_q};
    else if (hit_a)
      rd_mux = {20'h0, dac_a_q};
    else if (hit_b)
      rd_mux = {20'h0, dac_b_q};
    else if (hit_stage)
      rd_mux = {20'h0, stage_q};
    else if (hit_cfg)
      rd_mux = cfg_word;
    else if (hit_last)
      rd_mux = last_word;
    else if (hit_count)
      rd_mux = count_q;
    else
      rd_mux = 32'h0000_0000;
  end

  // Read data registered in the setup cycle so it stands through the access phase
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_mux;
  end

endmodule

`default_nettype wire

// *** bench/ddsl_host_model.sv ***
// Serial host model driving select, clock and data of the loader
`timescale 1ns/1ps
`default_nettype none

module ddsl_host_model
(
  output logic sclk,  // Serial clock, still outside frames
  output logic sel_n, // Select, active low
  output logic sdin   // Serial data
);
  initial
  begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdin = 1'b0;
  end

  // ****************************************************************
  // Frame: n bits of b from bit 31 down, 80 ns clock period
  // ****************************************************************
  task automatic send(input logic [31:0] b, input int n);
    #13 sel_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdin = b[31 - i];
      #20 sclk = 1'b1;
      #40 sclk = 1'b0;
      #20;
    end
    // Released data line shows the inverse, never a stale bit
    sdin = ~sdin;
    sel_n = 1'b1;
    // Long idle so the fabric sees a settled count; clock stands still
    #300;
  endtask
endmodule

`default_nettype wire

// *** bench/ddsl_top_assertions.sv ***
// Concurrent checks on the ports of the dual DAC serial loader
`timescale 1ns/1ps
`include "ddsl_defs.svh"
`default_nettype none

module ddsl_top_assertions
(
  input wire logic                 mclk,             // System clock
  input wire logic                 arst_n,           // Reset, active low
  input wire logic                 psel,             // APB select
  input wire logic                 penable,          // APB access
  input wire logic                 pwrite,           // APB write
  input wire logic [7:0]           paddr,            // APB address
  input wire logic [31:0]          prdata,           // APB read data
  input wire logic                 pslverr,          // APB error
  input wire logic                 sel_n,            // Serial select
  input wire ddsl_pkg::ddsl_code_t dac_a_code,       // Channel A
  input wire ddsl_pkg::ddsl_code_t dac_b_code,       // Channel B
  input wire logic                 speed_select,     // Fast mode
  input wire logic                 powerdown_select, // Power-down
  input wire logic [1:0]           reference_select  // Reference
);
  import ddsl_pkg::*;
  wire rd_acc = psel && penable && !pwrite;
  wire quiet  = sel_n && !(psel && pwrite);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  reset_clears_a: assert property ($rose(arst_n) |-> dac_a_code == 12'h0 &&
    dac_b_code == 12'h0 && {speed_select, powerdown_select, reference_select} == 4'h0)
    else $error("outputs not clear after reset");
  idle_codes_a: assert property (quiet [*8] |-> $stable(dac_a_code) && $stable(dac_b_code))
    else $error("channel code moved while deselected");
  idle_config_a: assert property (quiet [*8] |-> $stable({speed_select,
    powerdown_select, reference_select})) else $error("config moved while deselected");
  map_error_a: assert property (psel && penable && paddr[1:0] == 2'b00 |->
    pslverr == (paddr > `DDSL_OFF_COUNT)) else $error("error response wrong");
  unmapped_zero_a: assert property (rd_acc && paddr > `DDSL_OFF_COUNT |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  code_a_read_a: assert property (rd_acc && paddr == `DDSL_OFF_DAC_A && $stable(dac_a_code)
    |-> prdata == {20'h0, dac_a_code}) else $error("channel A readback wrong");
  code_b_read_a: assert property (rd_acc && paddr == `DDSL_OFF_DAC_B && $stable(dac_b_code)
    |-> prdata == {20'h0, dac_b_code}) else $error("channel B readback wrong");
  config_read_a: assert property (rd_acc && paddr == `DDSL_OFF_CONFIG &&
    $stable({powerdown_select, speed_select, reference_select}) |-> prdata ==
    {26'h0, powerdown_select, speed_select, 2'b00, reference_select})
    else $error("config readback wrong");
endmodule

bind ddsl_top ddsl_top_assertions chk_u (.mclk(mclk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .sel_n(sel_n), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
  .speed_select(speed_select), .powerdown_select(powerdown_select),
  .reference_select(reference_select));

`default_nettype wire

// *** bench/test_ddsl_top.sv ***
// Self-checking testbench of the dual DAC serial loader
`timescale 1ns/1ps
`include "ddsl_defs.svh"
`default_nettype none

module test_ddsl_top;
  import ddsl_pkg::*;
  logic        mclk, arst_n, psel, penable, pwrite, sclk, sel_n, sdin;
  logic        pready, pslverr, speed_select, powerdown_select, err, esp, epd;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  reference_select, er;
  ddsl_code_t  dac_a_code, dac_b_code, ea, eb, es;
  int          fails, tests_run;

  ddsl_top dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .sel_n(sel_n), .sdin(sdin), .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code), .speed_select(speed_select),
    .powerdown_select(powerdown_select), .reference_select(reference_select));
  ddsl_host_model host_u (.sclk(sclk), .sel_n(sel_n), .sdin(sdin));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Latches settle within a few system clocks after the frame
  task automatic xfer(input logic [31:0] b, input int n);
    host_u.send(b, n);
    repeat (6) @(posedge mclk);
  endtask
  task automatic upd(input logic [15:0] w);
    case ({w[15], w[12]})
      2'b00: {eb, es} = {w[11:0], w[11:0]};
      2'b01: es = w[11:0];
      2'b10: {ea, eb} = {w[11:0], es};
      default: er = w[1:0];
    endcase
    {esp, epd} = w[14:13];
  endtask
  task automatic outs_chk();
    check(dac_a_code, ea);
    check(dac_b_code, eb);
    check({powerdown_select, speed_select, reference_select}, {epd, esp, er});
    rdc(`DDSL_OFF_STAGE, es);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdc(`DDSL_OFF_CTRL, `DDSL_CTRL_RESET);
    for (int a = 4; a <= 24; a += 4)
      rdc(8'(a), 32'h0);
  endtask
  task automatic t_targets();
    logic [15:0] words [8] = '{16'h0abc, 16'h1123, 16'h8fff, 16'hd002,
                               16'hb003, 16'h9001, 16'h4000, 16'h2fff};
    foreach (words[i])
    begin
      xfer({words[i], 16'h0}, 16);
      upd(words[i]);
      outs_chk();
      rdc(`DDSL_OFF_LAST, {16'h0, words[i]});
    end
  endtask
  task automatic t_frame32();
    xfer({16'h0111, 16'h8222}, 32);
    upd(16'h0111);
    upd(16'h8222);
    outs_chk();
  endtask
  task automatic t_partial();
    xfer({12'h5a5, 20'h0}, 12);
    upd(16'h05a5);
    outs_chk();
    rdc(`DDSL_OFF_LAST, 32'h105a5);
  endtask
  task automatic t_ctrl();
    apb(1'b1, `DDSL_OFF_CTRL, 32'h0);
    xfer({16'h0777, 16'h0}, 16);
    outs_chk();
    rdc(`DDSL_OFF_COUNT, 32'd12);
    apb(1'b1, `DDSL_OFF_CTRL, 32'h3);
    repeat (2) @(posedge mclk);
    {ea, eb, es, er, esp, epd} = '0;
    outs_chk();
  endtask
  task automatic t_unmapped();
    apb(1'b0, 8'h1c, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    check(pready, 1'b1);
    apb(1'b1, `DDSL_OFF_DAC_A, 32'hfff);
    check(err, 1'b0);
    rdc(`DDSL_OFF_DAC_A, ea);
  endtask

  task automatic give_verdict();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, arst_n} = '0;
    {ea, eb, es, er, esp, epd} = '0;
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_targets();
    t_frame32();
    t_partial();
    t_ctrl();
    t_unmapped();
    give_verdict();
  end

  // Whole run needs well under a millisecond
  initial
  begin
    #1000000;
    fails++;
    give_verdict();
  end
endmodule

`default_nettype wire
